// >>> logic/dprs_top.sv
// Power rail sequencer with processor reset, boot strap and interrupt pin control
`timescale 1ns/10ps
module dprs_top
  import dprs_pkg::*;
#(
  parameter int STEP_CYCLES_P = STEP_CYCLES,
  parameter int OVERTEMP_STEPS_P = OVERTEMP_STEPS
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire dprs_good_t rail_good,
  input wire logic host_supply_ok,
  input wire logic overtemp_alarm_in,
  input wire logic host_alert_in,
  input wire logic dbg_reset_req,
  input wire logic wdog_trip_in,
  input wire logic [SW_W-1:0] user_switch_bank,
  input wire logic [NUM_PROCS-1:0][GPIO_W-1:0] proc_gpio_in,
  output logic [NUM_PROCS-1:0][GPIO_W-1:0] proc_gpio_out,
  output logic [NUM_PROCS-1:0][GPIO_W-1:0] proc_gpio_oe_n,
  output dprs_rails_t rail_enable,
  output logic [NUM_PROCS-1:0] proc_hold_reset_n,
  output logic red_reset_indicator,
  output logic i2c_xlat_enable,
  output logic mezz_geo_addr0,
  output logic mezz_geo_addr1,
  output logic param_mem_addr_sel2
);
  localparam int CW = $clog2(STEP_CYCLES_P + 1);
  localparam int HW = $clog2(OVERTEMP_STEPS_P + 1);

  typedef struct packed {
    dprs_state_t st;
    logic [CW-1:0] tick_cnt;
    logic [NUM_RAILS-1:0] rail_en;
    logic run;
    logic [HW-1:0] hot_cnt;
    logic [NUM_PROCS-1:0] hold;
    logic [NUM_PROCS-1:0][GPIO_W-1:0] gpio_out;
    logic [NUM_PROCS-1:0][GPIO_W-1:0] gpio_oe_n;
    logic xlat_en;
    logic led;
    logic geo;
    logic a2;
  } dprs_core_t;

  localparam dprs_core_t CORE_RESET = '{
    st: ST_WAIT_BASE,
    tick_cnt: '0,
    rail_en: '0,
    run: 1'b0,
    hot_cnt: '0,
    hold: '1,
    gpio_out: '0,
    gpio_oe_n: '0,
    xlat_en: 1'b0,
    led: 1'b1,
    geo: GEO_ADDR_LEVEL,
    a2: PARAM_MEM_A2_LEVEL
  };

  dprs_inputs_t raw_in;
  dprs_inputs_t s;
  dprs_core_t r_q;
  dprs_core_t r_d;
  logic tick;
  logic base_ok;
  logic rails_ok;
  logic all_ok;
  logic hot_trip;
  logic down_req;
  logic [NUM_RAILS-1:0] rail_goods;
  logic [BOOT_SEL_W-1:0] boot_sel [NUM_PROCS];

  always_comb
  begin
    raw_in.good = rail_good;
    raw_in.host_supply_ok = host_supply_ok;
    raw_in.overtemp_alarm = overtemp_alarm_in;
    raw_in.host_alert = host_alert_in;
    raw_in.dbg_reset_req = dbg_reset_req;
    raw_in.wdog_trip = wdog_trip_in;
    raw_in.user_switch_bank = user_switch_bank;
    for (int p = 0; p < NUM_PROCS; p++)
    begin
      raw_in.peer_reset_req[p] = proc_gpio_in[p][GP_RESET_PEER];
      raw_in.peer_irq_req[p] = proc_gpio_in[p][GP_IRQ_PEER];
    end
  end

  // Every pin input except resetn crosses in here before the state logic sees it
  dprs_sync #(
    .W($bits(dprs_inputs_t))
  ) u_sync (
    .mclk(mclk),
    .resetn(resetn),
    .d(raw_in),
    .q(s)
  ); // RULE19

  always_comb
  begin
    rail_goods = {s.good.good_0v75, s.good.good_1v5, s.good.good_1v8,
                  s.good.good_1v0, s.good.good_core_var, s.good.good_2v5};
    base_ok = s.good.good_3v3 & s.good.good_5v0 & s.good.good_2v3 &
              s.good.good_aux_1v8 & s.good.good_1v2;
    // Only rails already switched on are required good
    rails_ok = base_ok && ((rail_goods & r_q.rail_en) == r_q.rail_en);
    all_ok = base_ok && (&rail_goods);
    hot_trip = (r_q.hot_cnt == HW'(OVERTEMP_STEPS_P));
    down_req = !s.host_supply_ok || hot_trip; // RULE8
    tick = (r_q.tick_cnt == CW'(STEP_CYCLES_P - 1)); // RULE18
  end

  always_comb
  begin
    r_d = r_q;
    r_d.tick_cnt = tick ? '0 : r_q.tick_cnt + CW'(1);
    if (tick)
    begin
      if (!s.overtemp_alarm)
        r_d.hot_cnt = '0;
      else if (!hot_trip)
        r_d.hot_cnt = r_q.hot_cnt + HW'(1);
    end

    // Shutdown entry is immediate so reset is asserted before the next step drops a rail
    if (down_req && (r_q.rail_en != '0) && (r_q.st != ST_DOWN))
    begin
      r_d.st = ST_DOWN; // RULE8
    end
    else if (tick)
    begin
      unique case (r_q.st)
        ST_WAIT_BASE, ST_WAIT_2V5, ST_WAIT_CORE, ST_WAIT_1V0, ST_WAIT_1V8, ST_WAIT_1V5:
        begin
          if (rails_ok && !down_req)
          begin
            r_d.rail_en = r_q.rail_en | (NUM_RAILS'(1) << r_q.st); // RULE1 RULE2
            r_d.st = dprs_state_t'(r_q.st + 4'd1);
          end
        end
        ST_SETTLE_A, ST_SETTLE_B:
        begin
          if (rails_ok)
            r_d.st = dprs_state_t'(r_q.st + 4'd1); // RULE3
        end
        ST_SETTLE_C:
        begin
          if (all_ok)
            r_d.st = ST_HOLD; // RULE3
        end
        ST_HOLD:
        begin
          if (!all_ok)
            r_d.st = ST_DOWN;
          else if (!s.dbg_reset_req)
            r_d.st = ST_RUN; // RULE4
        end
        ST_RUN:
        begin
          if (!all_ok)
            r_d.st = ST_DOWN;
          else if (s.dbg_reset_req)
            r_d.st = ST_HOLD; // RULE6
          else
            r_d.run = 1'b1; // RULE5
        end
        ST_DOWN:
        begin
          if (r_q.rail_en == '0)
            r_d.st = ST_OFF;
          else
            r_d.rail_en = r_q.rail_en >> 1; // RULE7
        end
        ST_OFF:
        begin
          // Restart only once host supply failure and overtemperature timeout have gone away
          if (!down_req)
            r_d.st = ST_WAIT_BASE;
        end
        default:
        begin
          // Corrupt state code: safest exit is an ordered power down
          r_d.st = ST_DOWN;
        end
      endcase
    end

    if (r_d.st != ST_RUN)
      r_d.run = 1'b0; // RULE7

    for (int p = 0; p < NUM_PROCS; p++)
    begin
      // Peer request pins mean nothing until the peer is out of reset
      r_d.hold[p] = !r_d.run || s.wdog_trip ||
                    (!r_q.hold[p ^ 1] && s.peer_reset_req[p ^ 1]); // RULE10 RULE11
      boot_sel[p] = s.user_switch_bank[p * SW_PER_PROC +: BOOT_SEL_W];
      if (r_d.hold[p])
      begin
        r_d.gpio_out[p] = BOOT_PATTERN[boot_sel[p]]; // RULE9
        r_d.gpio_oe_n[p] = '0; // RULE9
      end
      else
      begin
        r_d.gpio_out[p] = '0;
        r_d.gpio_out[p][GP_TEMP_IRQ] = s.overtemp_alarm; // RULE10
        r_d.gpio_out[p][GP_ALERT_IRQ] = s.host_alert;
        r_d.gpio_out[p][GP_HOSTPG_IRQ] = s.host_supply_ok;
        r_d.gpio_out[p][GP_PEER_IRQ] = s.peer_irq_req[p ^ 1] && !r_q.hold[p ^ 1];
        r_d.gpio_out[p][GP_STATUS] = 1'b0;
        r_d.gpio_oe_n[p] = ~GP_DRIVEN_MASK; // RULE10
      end
    end
    r_d.xlat_en = !r_d.hold[0] && !r_d.hold[1]; // RULE12
    r_d.led = |r_d.hold; // RULE15
    r_d.geo = GEO_ADDR_LEVEL; // RULE13
    r_d.a2 = PARAM_MEM_A2_LEVEL; // RULE14
  end

  always_ff @(posedge mclk) // RULE16
  begin
    if (!resetn)
      r_q <= CORE_RESET;
    else
      r_q <= r_d;
  end

  assign rail_enable = dprs_rails_t'(r_q.rail_en);
  assign proc_hold_reset_n = ~r_q.hold; // RULE17
  assign proc_gpio_out = r_q.gpio_out;
  assign proc_gpio_oe_n = r_q.gpio_oe_n;
  assign red_reset_indicator = r_q.led;
  assign i2c_xlat_enable = r_q.xlat_en;
  assign mezz_geo_addr0 = r_q.geo;
  assign mezz_geo_addr1 = r_q.geo;
  assign param_mem_addr_sel2 = r_q.a2;

  default clocking dprs_cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  chk_first_rail: assert property ($rose(r_q.rail_en[0]) |-> $past(r_q.st) == ST_WAIT_BASE && $past(base_ok)) // RULE1
    else $error("2V5 rail enabled without base rails good");

  chk_rail_order: assert property (((r_q.rail_en + NUM_RAILS'(1)) & r_q.rail_en) == '0) // RULE2
    else $error("Rail enables not contiguous from the first rail");

  chk_reach_hold: assert property ($changed(r_q.st) && r_q.st == ST_HOLD && $past(r_q.st) == ST_SETTLE_C
                                   |-> $past(all_ok) && r_q.hold == '1) // RULE3
    else $error("Hold state reached without all rails good");

  chk_dbg_stays: assert property (r_q.st == ST_HOLD && tick && s.dbg_reset_req && all_ok && !down_req
                                  |=> r_q.st == ST_HOLD && r_q.hold == '1) // RULE4
    else $error("Left hold state during debug reset request");

  chk_release_run: assert property (!r_q.hold[0] || !r_q.hold[1] |-> r_q.st == ST_RUN && r_q.run) // RULE5
    else $error("Processor released outside run state");

  chk_dbg_reenter: assert property (r_q.st == ST_RUN && tick && s.dbg_reset_req && all_ok && !down_req
                                    |=> r_q.st == ST_HOLD ##0 r_q.hold == '1) // RULE6
    else $error("Debug request in run did not reassert reset");

  chk_down_reset: assert property ((r_q.rail_en & ~$past(r_q.rail_en)) == '0 && r_q.rail_en != $past(r_q.rail_en)
                                   |-> $past(r_q.hold) == '1) // RULE7
    else $error("Rail removed while a processor was running");

  chk_host_fail: assert property (!s.host_supply_ok && r_q.rail_en != '0 |=> r_q.st inside {ST_DOWN, ST_OFF}
                                  ##1 r_q.hold == '1) // RULE8
    else $error("Host supply failure did not start power down");

  chk_boot_drive: assert property (r_q.hold[0] |-> r_q.gpio_oe_n[0] == '0 && r_q.gpio_out[0] inside {BOOT_PATTERN}) // RULE9
    else $error("Boot pins not driven during reset");

  chk_xlat_off: assert property (r_q.xlat_en |-> r_q.hold == '0) // RULE12
    else $error("Translator enabled while a processor is in reset");

  chk_fixed_pins: assert property (mezz_geo_addr0 && mezz_geo_addr1 && !param_mem_addr_sel2) // RULE13 RULE14
    else $error("Address strap outputs wrong");

  chk_led_track: assert property (red_reset_indicator == (proc_hold_reset_n != '1)) // RULE15
    else $error("Reset indicator does not follow processor reset");

  chk_step_gap: assert property ($changed(r_q.st) && r_q.st != ST_DOWN |-> $past(tick)) // RULE18
    else $error("State advanced between steps");

  chk_step_bound: assert property (r_q.tick_cnt <= CW'(STEP_CYCLES_P - 1)) // RULE18
    else $error("Step counter ran past its period");

  chk_down_shift: assert property (r_q.st == ST_DOWN && $changed(r_q.rail_en)
                                   |-> r_q.rail_en == ($past(r_q.rail_en) >> 1)) // RULE7
    else $error("Power down skipped or reordered a rail");

  chk_off_quiet: assert property (r_q.st inside {ST_OFF, ST_WAIT_BASE} |-> r_q.rail_en == '0) // RULE7
    else $error("Rail left on while sequencer is off");

  chk_settle_hold: assert property (r_q.st inside {ST_SETTLE_A, ST_SETTLE_B, ST_SETTLE_C, ST_HOLD}
                                    |-> r_q.rail_en == '1 && r_q.hold == '1) // RULE3
    else $error("Waiting states changed rails or released reset");

  chk_run_entry: assert property (r_q.st == ST_RUN |-> $past(r_q.st) inside {ST_HOLD, ST_RUN}) // RULE4
    else $error("Run state entered other than from hold");

  chk_temp_trip: assert property (hot_trip && r_q.rail_en != '0 |=> r_q.st inside {ST_DOWN, ST_OFF}) // RULE8
    else $error("Overtemperature timeout did not start power down");

  chk_hot_clear: assert property (tick && !s.overtemp_alarm |=> r_q.hot_cnt == '0) // RULE8
    else $error("Alarm count not cleared by a quiet step");

  chk_wdog_hold: assert property (s.wdog_trip |=> r_q.hold == '1) // RULE10
    else $error("Watchdog trip did not hold both processors");

  chk_first_resets: assert property (s.peer_reset_req[0] && !r_q.hold[0] |=> r_q.hold[1]) // RULE11
    else $error("First processor could not reset the second");

  chk_second_resets: assert property (s.peer_reset_req[1] && !r_q.hold[1] |=> r_q.hold[0]) // RULE11
    else $error("Second processor could not reset the first");

  chk_irq_drive: assert property (!r_q.hold[0] |-> r_q.gpio_oe_n[0] == ~GP_DRIVEN_MASK) // RULE10
    else $error("Interrupt pins not driven after release");

  chk_alert_fwd: assert property (!r_q.hold[0]
                                  |-> r_q.gpio_out[0][GP_ALERT_IRQ] == $past(s.host_alert)) // RULE10
    else $error("Host alert not forwarded to the processor");

  chk_boot_first: assert property (r_q.hold[0]
                                   |-> r_q.gpio_out[0] == BOOT_PATTERN[$past(s.user_switch_bank[1:0])]) // RULE9
    else $error("First processor boot pattern does not follow switches");

  chk_boot_second: assert property (r_q.hold[1]
                                    |-> r_q.gpio_out[1] == BOOT_PATTERN[$past(s.user_switch_bank[5:4])]) // RULE9
    else $error("Second processor boot pattern does not follow switches");

  chk_peer_irq: assert property ($past(r_q.hold[1]) && !r_q.hold[0] |-> !r_q.gpio_out[0][GP_PEER_IRQ]) // RULE10
    else $error("Interrupt passed from a processor held in reset");

  chk_xlat_on: assert property (r_q.hold == '0 |-> r_q.xlat_en) // RULE12
    else $error("Translator not enabled with both processors released");

  cov_release: cover property (r_q.st == ST_RUN && r_q.hold == '0);
  cov_dbg_back: cover property (r_q.st == ST_RUN ##1 r_q.st == ST_HOLD);
  cov_power_down: cover property (r_q.st == ST_DOWN ##1 r_q.st == ST_OFF);
  cov_peer_reset: cover property (r_q.hold == 2'b10);
  cov_wdog_hold: cover property (s.wdog_trip ##1 r_q.hold == '1);
endmodule

// >>> logic/dprs_pkg.sv
// Constants, carrier types and state encoding for the processor power and reset sequencer
// Summary of operation
// [RULE1] Base rails good: enable 2V5, advance
// [RULE2] States one to five enable rails in order
// [RULE3] States six to eight wait; nine needs all
// [RULE4] Hold in nine while debug reset requested
// [RULE5] State ten, all good: release processor reset
// [RULE6] Debug request in ten: reassert reset, nine
// [RULE7] Power down reverses order, reset first
// [RULE8] Overtemperature timeout or host failure powers down
// [RULE9] In reset, drive boot pattern from switches
// [RULE10] After reset, pins carry interrupts and watchdog
// [RULE11] First processor may reset the second
// [RULE12] Bus translator enabled after both processors released
// [RULE13] Both mezzanine geographic address outputs high
// [RULE14] Parameter memory upper address select low
// [RULE15] Red indicator on while reset asserted
// [RULE16] Everything clocked from the one clock
// [RULE17] Names ending _n are active low
// [RULE18] Ten millisecond step before each evaluation
// [RULE19] Asynchronous inputs pass two flip-flops
package dprs_pkg;

  localparam int CLK_MHZ = 50;
  localparam int STEP_TIME_MS = 10;
  localparam int STEP_CYCLES = STEP_TIME_MS * 1000 * CLK_MHZ;
  // Alarm must persist this many steps before it counts as a timeout
  localparam int OVERTEMP_STEPS = 100;

  localparam int NUM_RAILS = 6;
  localparam int NUM_PROCS = 2;
  localparam int GPIO_W = 17;
  localparam int SW_W = 8;
  localparam int SW_PER_PROC = 4;
  localparam int BOOT_SEL_W = 2;

  localparam int GP_TEMP_IRQ = 0;
  localparam int GP_ALERT_IRQ = 1;
  localparam int GP_HOSTPG_IRQ = 2;
  localparam int GP_PEER_IRQ = 3;
  localparam int GP_STATUS = 4;
  localparam int GP_RESET_PEER = 6;
  localparam int GP_IRQ_PEER = 7;
  localparam logic [GPIO_W-1:0] GP_DRIVEN_MASK = 17'h0_001F;

  localparam logic [GPIO_W-1:0] BOOT_PATTERN [0:3] = '{17'h0_0000, 17'h0_0002, 17'h0_0004, 17'h0_0006};

  localparam logic GEO_ADDR_LEVEL = 1'b1;
  localparam logic PARAM_MEM_A2_LEVEL = 1'b0;

  typedef struct packed {
    logic good_3v3;
    logic good_5v0;
    logic good_2v3;
    logic good_aux_1v8;
    logic good_1v2;
    logic good_2v5;
    logic good_core_var;
    logic good_1v0;
    logic good_1v8;
    logic good_1v5;
    logic good_0v75;
  } dprs_good_t;

  // Bit 0 is the first rail up, so power down is a right shift
  typedef struct packed {
    logic enable_rail_0v75;
    logic enable_rail_1v5;
    logic enable_rail_1v8;
    logic enable_rail_1v0;
    logic enable_core_var_rail;
    logic enable_rail_2v5;
  } dprs_rails_t;

  typedef struct packed {
    dprs_good_t good;
    logic host_supply_ok;
    logic overtemp_alarm;
    logic host_alert;
    logic dbg_reset_req;
    logic wdog_trip;
    logic [SW_W-1:0] user_switch_bank;
    logic [NUM_PROCS-1:0] peer_reset_req;
    logic [NUM_PROCS-1:0] peer_irq_req;
  } dprs_inputs_t;

  typedef enum logic [3:0] {
    ST_WAIT_BASE,
    ST_WAIT_2V5,
    ST_WAIT_CORE,
    ST_WAIT_1V0,
    ST_WAIT_1V8,
    ST_WAIT_1V5,
    ST_SETTLE_A,
    ST_SETTLE_B,
    ST_SETTLE_C,
    ST_HOLD,
    ST_RUN,
    ST_DOWN,
    ST_OFF
  } dprs_state_t;

endpackage

// >>> logic/dprs_sync.sv
// Two-stage synchroniser for a bundle of asynchronous levels
`timescale 1ns/10ps
module dprs_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dprs_sync_state_t;

  dprs_sync_state_t r_q;
  dprs_sync_state_t r_d;

  always_comb
  begin
    r_d.meta = d;
    r_d.stable = r_q.meta;
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn)
      r_q <= '0;
    else
      r_q <= r_d;
  end

  assign q = r_q.stable;
endmodule

// >>> verification/dprs_psu_model.sv
// Supply regulator model: each switched rail's power-good follows its enable after a lag
`timescale 1ns/10ps
module dprs_psu_model
  import dprs_pkg::*;
#(
  parameter int LAG = 3
) (
  input wire logic mclk,
  input wire dprs_rails_t rail_enable,
  input wire dprs_good_t fail_mask,
  output dprs_good_t rail_good
);
  logic [5:0] lag_q [0:LAG-1];

  always_ff @(posedge mclk)
  begin
    lag_q[0] <= {<<{rail_enable}};
    for (int i = 1; i < LAG; i++)
    begin
      lag_q[i] <= lag_q[i-1];
    end
  end

  // Base rails on unless masked; a good drops after the lag, or at once through fail_mask
  assign rail_good = {5'h1F, lag_q[LAG-1]} & ~fail_mask;
endmodule

// >>> verification/dprs_top_test.sv
// Self-checking bench for the power and reset sequencer
`timescale 1ns/10ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) \
  begin failures++; $display("ERROR %0t got %h expected %h", $time, a, b); end end
module dprs_top_test
  import dprs_pkg::*;
;
  localparam int STEP = 8;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  dprs_good_t fail_mask = '0;
  dprs_good_t rail_good;
  logic host_ok = 1'b1;
  logic alarm = 1'b0;
  logic alert = 1'b0;
  logic dbg = 1'b0;
  logic wdog = 1'b0;
  logic [SW_W-1:0] sw = 8'h21;
  logic [NUM_PROCS-1:0][GPIO_W-1:0] g_in;
  logic [NUM_PROCS-1:0][GPIO_W-1:0] g_out;
  logic [NUM_PROCS-1:0][GPIO_W-1:0] g_oen;
  logic [NUM_PROCS-1:0][GPIO_W-1:0] g_drv = '0;
  dprs_rails_t rails;
  logic [NUM_PROCS-1:0] hold_n;
  logic red;
  logic xlat;
  logic geo0;
  logic geo1;
  logic a2;

  // Pin level: design wins wherever it drives
  assign g_in = (g_out & ~g_oen) | (g_drv & g_oen);

  dprs_psu_model psu (.mclk(mclk), .rail_enable(rails), .fail_mask(fail_mask), .rail_good(rail_good));

  dprs_top #(.STEP_CYCLES_P(STEP), .OVERTEMP_STEPS_P(3)) DUT (.mclk(mclk), .resetn(resetn),
    .rail_good(rail_good), .host_supply_ok(host_ok), .overtemp_alarm_in(alarm), .host_alert_in(alert),
    .dbg_reset_req(dbg), .wdog_trip_in(wdog), .user_switch_bank(sw), .proc_gpio_in(g_in),
    .proc_gpio_out(g_out), .proc_gpio_oe_n(g_oen), .rail_enable(rails), .proc_hold_reset_n(hold_n),
    .red_reset_indicator(red), .i2c_xlat_enable(xlat), .mezz_geo_addr0(geo0), .mezz_geo_addr1(geo1),
    .param_mem_addr_sel2(a2));

  initial
  begin
    forever
    begin
      #10 mclk = ~mclk;
    end
  end

  task automatic test_done();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      failures++;
      test_done();
    end
  end

  // Bounded wait so a missed intermediate value shows as a mismatch
  task automatic wait_outs(input logic [5:0] r, input logic [1:0] h);
    int n;
    n = 0;
    while ((rails !== r || hold_n !== h) && n < 300)
    begin
      @(negedge mclk);
      n++;
    end
    `CHK(rails, r);
    `CHK(hold_n, h);
  endtask

  task automatic bring_up();
    for (int i = 1; i <= 6; i++)
    begin
      wait_outs((6'h01 << i) - 6'h01, 2'b00);
    end
  endtask

  task automatic down_seq();
    logic [5:0] r;
    r = 6'h3F;
    wait_outs(r, 2'b00);
    repeat (6)
    begin
      r = r >> 1;
      wait_outs(r, 2'b00);
    end
  endtask

  task automatic t_reset();
    repeat (3) @(negedge mclk);
    `CHK(geo0, 1'b1);
    `CHK(geo1, 1'b1);
    `CHK(a2, 1'b0);
    `CHK(red, 1'b1);
    `CHK(xlat, 1'b0);
    `CHK(g_oen, '0);
    `CHK(g_out[0], BOOT_PATTERN[1]);
    `CHK(g_out[1], BOOT_PATTERN[2]);
  endtask

  task automatic t_up();
    fail_mask.good_0v75 = 1'b1;
    dbg = 1'b1;
    bring_up();
    repeat (20 * STEP) @(negedge mclk);
    `CHK(hold_n, 2'b00);
    `CHK(rails, 6'h3F);
    fail_mask = '0;
    repeat (20 * STEP) @(negedge mclk);
    `CHK(hold_n, 2'b00);
    dbg = 1'b0;
    wait_outs(6'h3F, 2'b11);
    `CHK(red, 1'b0);
    `CHK(xlat, 1'b1);
    `CHK(g_oen[0], ~GP_DRIVEN_MASK);
    `CHK(g_out[1][2], 1'b1);
  endtask

  task automatic t_dbg();
    dbg = 1'b1;
    wait_outs(6'h3F, 2'b00);
    dbg = 1'b0;
    wait_outs(6'h3F, 2'b11);
  endtask

  task automatic t_peer();
    g_drv[0][6] = 1'b1;
    wait_outs(6'h3F, 2'b01);
    `CHK(xlat, 1'b0);
    `CHK(red, 1'b1);
    g_drv[0][6] = 1'b0;
    wait_outs(6'h3F, 2'b11);
    g_drv[1][6] = 1'b1;
    wait_outs(6'h3F, 2'b10);
    g_drv[1][6] = 1'b0;
    wait_outs(6'h3F, 2'b11);
    alert = 1'b1;
    g_drv[0][7] = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK(g_out[0][1], 1'b1);
    `CHK(g_out[1][3], 1'b1);
    `CHK(g_out[0][3], 1'b0);
    alert = 1'b0;
    g_drv[0][7] = 1'b0;
    wdog = 1'b1;
    wait_outs(6'h3F, 2'b00);
    wdog = 1'b0;
    wait_outs(6'h3F, 2'b11);
  endtask

  task automatic t_host();
    host_ok = 1'b0;
    down_seq();
    host_ok = 1'b1;
    bring_up();
    wait_outs(6'h3F, 2'b11);
  endtask

  task automatic t_temp();
    alarm = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK(g_out[0][0], 1'b1);
    down_seq();
  endtask

  initial
  begin
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    t_reset();
    t_up();
    t_dbg();
    t_peer();
    t_host();
    t_temp();
    test_done();
  end
endmodule
